// file: inc/tpwm_pkg.sv
// Purpose: Shared constants and types of the 16-bit timer waveform block
// Assumes: Register word offsets are byte addresses on a 32-bit Avalon-MM slave
// Notes:   Field positions and encodings are gathered here so the logic has no bare numbers
package tpwm_pkg;

   localparam int CW = 16;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL  = 5'h00;
   localparam logic [4:0] OFS_COUNT = 5'h04;
   localparam logic [4:0] OFS_CMP_A = 5'h08;
   localparam logic [4:0] OFS_CMP_B = 5'h0c;
   localparam logic [4:0] OFS_CAPT  = 5'h10;
   localparam logic [4:0] OFS_FLAGS = 5'h14;
   localparam logic [4:0] OFS_PORT  = 5'h18;

   // Waveform modes handled by this block
   localparam logic [3:0] WGM_CTC_A     = 4'h4;
   localparam logic [3:0] WGM_FAST8     = 4'h5;
   localparam logic [3:0] WGM_FAST9     = 4'h6;
   localparam logic [3:0] WGM_FAST10    = 4'h7;
   localparam logic [3:0] WGM_CTC_CAPT  = 4'hc;
   localparam logic [3:0] WGM_FAST_CAPT = 4'he;
   localparam logic [3:0] WGM_FAST_A    = 4'hf;

   // Count limits and fixed TOP values
   localparam logic [CW-1:0] TOP_8        = 16'h00ff;
   localparam logic [CW-1:0] TOP_9        = 16'h01ff;
   localparam logic [CW-1:0] TOP_10       = 16'h03ff;
   localparam logic [CW-1:0] COUNT_MAX    = 16'hffff;
   localparam logic [CW-1:0] COUNT_BOTTOM = 16'h0000;

   // Output modes per channel
   localparam logic [1:0] OM_OFF    = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR  = 2'h2;
   localparam logic [1:0] OM_SET    = 2'h3;

   // Prescaler selections and divider masks
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [2:0] CS_DIV8    = 3'h2;
   localparam logic [2:0] CS_DIV64   = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam int         PS_W       = 10;
   localparam logic [PS_W-1:0] PS_MASK_8    = 10'h007;
   localparam logic [PS_W-1:0] PS_MASK_64   = 10'h03f;
   localparam logic [PS_W-1:0] PS_MASK_256  = 10'h0ff;
   localparam logic [PS_W-1:0] PS_MASK_1024 = 10'h3ff;

   // Flag bit positions
   localparam int FLG_WRAP    = 0;
   localparam int FLG_MATCH_A = 1;
   localparam int FLG_MATCH_B = 2;
   localparam int FLG_CAPT    = 3;
   localparam int FLG_W       = 4;

   typedef struct packed {
      logic [1:0] out_mode_b;
      logic [1:0] out_mode_a;
      logic [2:0] clk_sel;
      logic [3:0] waveform_mode_sel;
   } tpwm_ctrl_t;

   typedef struct packed {
      logic [1:0] port_val;
      logic [1:0] wave_pin_dir;
   } tpwm_port_t;

   typedef struct packed {
      logic match;
      logic bottom;
      logic pwm;
   } tpwm_evt_t;

   localparam tpwm_ctrl_t CTRL_RESET = '0;
   localparam tpwm_port_t PORT_RESET = '0;

endpackage

// file: core/tpwm_prescaler.sv
// Purpose: Timer tick generator dividing the I/O clock
// Assumes: Divider selection may change at any time; a stale phase is harmless
// Notes:   One free running count serves every division factor above 1
`timescale 1ns/100ps
module tpwm_prescaler
   import tpwm_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // Selection and tick
   input  wire logic [2:0] clk_sel,
   output logic            tick
);
   import tpwm_pkg::*;

   logic [PS_W-1:0] div_count;

   function automatic logic [PS_W-1:0] div_mask(input logic [2:0] sel);
      case (sel)
         CS_DIV8:    div_mask = PS_MASK_8;
         CS_DIV64:   div_mask = PS_MASK_64;
         CS_DIV256:  div_mask = PS_MASK_256;
         CS_DIV1024: div_mask = PS_MASK_1024;
         default:    div_mask = '0;
      endcase
   endfunction

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         div_count <= '0;
      else
         div_count <= div_count + 1'b1;
   end

   // Unknown selections stop the timer rather than guess a factor
   always_comb
   begin
      if (clk_sel == CS_DIV1)
         tick = 1'b1;
      else if (clk_sel == CS_STOP || div_mask(clk_sel) == '0)
         tick = 1'b0;
      else
         tick = ((div_count & div_mask(clk_sel)) == div_mask(clk_sel));
   end

endmodule

// file: core/tpwm_out_unit.sv
// Purpose: Compare output state and pin override of one channel
// Assumes: Events are already qualified with the timer tick
// Notes:   When TOP and compare coincide, the BOTTOM action wins
`timescale 1ns/100ps
module tpwm_out_unit
   import tpwm_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      reset_n,
   // Timer events and configuration
   input  tpwm_pkg::tpwm_evt_t evt,
   input  wire logic [1:0] out_mode_ch,
   input  wire logic      toggle_ok,
   input  wire logic      wave_pin_dir,
   input  wire logic      port_val,
   // Pin
   output logic           wave_state,
   output logic           pin_o,
   output logic           pin_oe_n
);
   import tpwm_pkg::*;

   logic next_state;

   always_comb
   begin
      next_state = wave_state;
      if (evt.pwm)
      begin
         case (out_mode_ch)
            OM_TOGGLE: if (evt.match && toggle_ok) next_state = ~wave_state;
            // Set at BOTTOM has priority so compare equal to TOP gives a steady level
            OM_CLEAR:  if (evt.bottom) next_state = 1'b1;
                       else if (evt.match) next_state = 1'b0;
            OM_SET:    if (evt.bottom) next_state = 1'b0;
                       else if (evt.match) next_state = 1'b1;
            default:   next_state = wave_state;
         endcase
      end
      else if (evt.match)
      begin
         case (out_mode_ch)
            OM_TOGGLE: next_state = ~wave_state;
            OM_CLEAR:  next_state = 1'b0;
            OM_SET:    next_state = 1'b1;
            default:   next_state = wave_state;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         wave_state <= 1'b0;
      else
         wave_state <= next_state;
   end

   // Pin follows the new state in the same cycle it is decided
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pin_o    <= 1'b0;
         pin_oe_n <= 1'b1;
      end
      else
      begin
         pin_o    <= (out_mode_ch != OM_OFF) ? next_state : port_val;
         pin_oe_n <= ~wave_pin_dir;
      end
   end

endmodule

// file: core/tpwm_core.sv
// Purpose: 16-bit timer waveform generator, clear-on-match and fast PWM modes
// Assumes: Avalon-MM slave with waitrequest, 32-bit data, 125 MHz clk
// Notes:   Normal and dual-slope modes run as a plain free counter without clearing
//
// Functional notes
// - Modes 4 and 12 clear the count when it equals compare A or capture.
// - Clear-on-match sets the flag of the register defining TOP at TOP.
// - Clear-on-match TOP is unbuffered; below count means running through 0xFFFF.
// - Channel A output mode 1 toggles on every match in clear-on-match.
// - Pin is driven only while its direction bit selects output.
// - Clear-on-match sets the wrap flag when the count rolls from max to zero.
// - Fast PWM modes 5, 6, 7, 14, 15 count up BOTTOM to TOP, restart.
// - Fast PWM TOP is 0x00FF, 0x01FF, 0x03FF, capture or compare A.
// - Output mode 2 clears on match, sets at BOTTOM; mode 3 inverse.
// - Fast PWM sets wrap flag at TOP plus the TOP register's flag.
// - Fixed TOP modes zero compare bits above resolution on every write.
// - Capture as TOP is unbuffered; lower value means wrap before match.
// - Fast PWM compare writes buffer; active value loads at TOP, but a write to that compare in the TOP cycle skips the load.
// - Compare zero gives one-cycle spike; compare equal TOP a steady level.
// - Fast PWM channel A mode 1 toggles on match, compare buffered.
// - Timer tick is the clock divided by 1, 8, 64, 256 or 1024.
// - Fast PWM sets a channel's match flag when count equals compare.
// - Output mode zero leaves the channel state unchanged on match.
// - Nonzero output mode replaces the general port value on the pin.
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module tpwm_core
   import tpwm_pkg::*;
#(
   parameter int NCH = 2
)
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Avalon-MM slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Waveform pins, channel A then B
   output logic [NCH-1:0]   wave_pin_o,
   output logic [NCH-1:0]   wave_pin_oe_n,
   // Status for observation
   output logic [CW-1:0]    count_value
);
   import tpwm_pkg::*;

   tpwm_ctrl_t       ctrl;
   tpwm_port_t       port;
   logic [CW-1:0]    compare_buf [NCH];
   logic [CW-1:0]    compare_value [NCH];
   logic [CW-1:0]    capture_value;
   logic [FLG_W-1:0] flags;
   logic [FLG_W-1:0] flag_set;
   logic [NCH-1:0]   wave_out_ch;
   logic [NCH-1:0]   ch_match;
   logic             tick;
   logic             bus_wr;
   logic             is_pwm;
   logic             top_from_capt;
   logic             top_from_cmp_a;
   logic             does_clear;
   logic [CW-1:0]    top_value;
   logic             at_top;
   logic             clear_evt;
   logic             wrap_evt;
   logic [CW-1:0]    wr_merged;
   logic [31:0]      old_word;
   logic [31:0]      wr_word;

   function automatic logic is_fast(input logic [3:0] m);
      is_fast = (m == WGM_FAST8) || (m == WGM_FAST9) || (m == WGM_FAST10) ||
                (m == WGM_FAST_CAPT) || (m == WGM_FAST_A);
   endfunction

   // Fixed resolution mask; all ones when TOP comes from a register
   function automatic logic [CW-1:0] fixed_top(input logic [3:0] m);
      case (m)
         WGM_FAST8:  fixed_top = TOP_8;
         WGM_FAST9:  fixed_top = TOP_9;
         WGM_FAST10: fixed_top = TOP_10;
         default:    fixed_top = COUNT_MAX;
      endcase
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
            r[8*b +: 8] = new_v[8*b +: 8];
      end
      be_merge = r;
   endfunction

   // Bus handshake: one wait cycle, then the access completes
   assign bus_wr = avs_write && !avs_waitrequest;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_waitrequest <= 1'b1;
      else if ((avs_read || avs_write) && avs_waitrequest)
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         avs_readdata <= '0;
      else if (avs_read && avs_waitrequest)
      begin
         case (avs_address)
            OFS_CTRL:  avs_readdata <= 32'(ctrl);
            OFS_COUNT: avs_readdata <= 32'(count_value);
            OFS_CMP_A: avs_readdata <= 32'(compare_buf[0]);
            OFS_CMP_B: avs_readdata <= 32'(compare_buf[1]);
            OFS_CAPT:  avs_readdata <= 32'(capture_value);
            OFS_FLAGS: avs_readdata <= 32'(flags);
            OFS_PORT:  avs_readdata <= 32'(port);
            default:   avs_readdata <= '0;
         endcase
      end
   end

   // Shared merge of the write data with the old word at the address
   always_comb
   begin
      case (avs_address)
         OFS_CTRL:  old_word = 32'(ctrl);
         OFS_PORT:  old_word = 32'(port);
         OFS_COUNT: old_word = 32'(count_value);
         OFS_CMP_A: old_word = 32'(compare_buf[0]);
         OFS_CMP_B: old_word = 32'(compare_buf[1]);
         OFS_CAPT:  old_word = 32'(capture_value);
         default:   old_word = '0;
      endcase
      wr_word   = be_merge(old_word, avs_writedata, avs_byteenable);
      wr_merged = wr_word[CW-1:0];
   end

   // Configuration registers; output modes take effect at once
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= CTRL_RESET;
         port <= PORT_RESET;
      end
      else if (bus_wr && avs_address == OFS_CTRL)
         ctrl <= tpwm_ctrl_t'(wr_word[$bits(tpwm_ctrl_t)-1:0]);
      else if (bus_wr && avs_address == OFS_PORT)
         port <= tpwm_port_t'(wr_word[$bits(tpwm_port_t)-1:0]);
   end

   tpwm_prescaler u_prescaler
   (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_sel (ctrl.clk_sel),
      .tick    (tick)
   );

   // TOP selection
   always_comb
   begin
      is_pwm         = is_fast(ctrl.waveform_mode_sel);
      top_from_capt  = (ctrl.waveform_mode_sel == WGM_CTC_CAPT) ||
                       (ctrl.waveform_mode_sel == WGM_FAST_CAPT);
      top_from_cmp_a = (ctrl.waveform_mode_sel == WGM_CTC_A) ||
                       (ctrl.waveform_mode_sel == WGM_FAST_A);
      does_clear     = is_pwm || top_from_capt || top_from_cmp_a;
      if (top_from_capt)
         top_value = capture_value;
      else if (top_from_cmp_a)
         top_value = compare_value[0];
      else
         top_value = fixed_top(ctrl.waveform_mode_sel);
   end

   // Equality only: a TOP written below the count is passed and found after the wrap
   assign at_top    = (count_value == top_value);
   assign clear_evt = tick && does_clear && at_top;
   assign wrap_evt  = tick && (is_pwm ? at_top : (count_value == COUNT_MAX));

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         count_value <= COUNT_BOTTOM;
      else if (bus_wr && avs_address == OFS_COUNT)
         count_value <= wr_merged;
      else if (clear_evt)
         count_value <= COUNT_BOTTOM;
      else if (tick)
         count_value <= count_value + 1'b1;
   end

   // Capture register is written only by software here and never buffered
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         capture_value <= COUNT_BOTTOM;
      else if (bus_wr && avs_address == OFS_CAPT)
         capture_value <= wr_merged;
   end

   genvar i;
   generate
      for (i = 0; i < NCH; i++)
      begin : g_ch
         localparam logic [4:0] OFS = (i == 0) ? OFS_CMP_A : OFS_CMP_B;
         tpwm_evt_t evt;

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
            begin
               compare_buf[i]   <= COUNT_BOTTOM;
               compare_value[i] <= COUNT_BOTTOM;
            end
            else if (bus_wr && avs_address == OFS)
            begin
               compare_buf[i] <= wr_merged & fixed_top(ctrl.waveform_mode_sel);
               if (!is_pwm)
                  compare_value[i] <= wr_merged & fixed_top(ctrl.waveform_mode_sel);
            end
            else if (clear_evt && is_pwm)
               compare_value[i] <= compare_buf[i];
         end

         assign ch_match[i] = tick && (count_value == compare_value[i]);
         assign evt.match   = ch_match[i];
         assign evt.bottom  = clear_evt && is_pwm;
         assign evt.pwm     = is_pwm;

         tpwm_out_unit u_out
         (
            .clk          (clk),
            .reset_n      (reset_n),
            .evt          (evt),
            .out_mode_ch  ((i == 0) ? ctrl.out_mode_a : ctrl.out_mode_b),
            .toggle_ok    (i == 0),
            .wave_pin_dir (port.wave_pin_dir[i]),
            .port_val     (port.port_val[i]),
            .wave_state   (wave_out_ch[i]),
            .pin_o        (wave_pin_o[i]),
            .pin_oe_n     (wave_pin_oe_n[i])
         );
      end
   endgenerate

   // Flags: hardware set wins over a write-one-to-clear in the same cycle
   always_comb
   begin
      flag_set              = '0;
      flag_set[FLG_WRAP]    = wrap_evt;
      flag_set[FLG_MATCH_A] = ch_match[0] || (clear_evt && top_from_cmp_a);
      flag_set[FLG_MATCH_B] = ch_match[1];
      flag_set[FLG_CAPT]    = clear_evt && top_from_capt;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         flags <= '0;
      else if (bus_wr && avs_address == OFS_FLAGS)
         flags <= (flags & ~(avs_writedata[FLG_W-1:0] & {FLG_W{avs_byteenable[0]}}))
                  | flag_set;
      else
         flags <= flags | flag_set;
   end

endmodule

// file: tb/tpwm_load.sv
// Purpose: Load on the waveform pins, with a weak pull-down on each pin
// Assumes: A released pin settles at the pull-down level within one cycle
// Notes:   The bench measures duty on the level seen here
`timescale 1ns/100ps
module tpwm_load
(
   // Pins from the block
   input  wire logic [1:0] wave_pin_o,
   input  wire logic [1:0] wave_pin_oe_n,
   // Level seen by the load
   output logic [1:0]      pin_level
);
   // Undriven pins fall to the pull-down, never to a stale value
   assign pin_level = wave_pin_o & ~wave_pin_oe_n;
endmodule

// file: tb/tpwm_checker.sv
// Purpose: Port-level assertions of the timer waveform block
// Assumes: Software writes whole words; shadows follow completed writes
// Notes:   Shadows hold CTRL, PORT and capture as the block holds them
`timescale 1ns/100ps
module tpwm_checker
   import tpwm_pkg::*;
#(
   parameter int NCH = 2
)
(
   // Clock and reset
   input wire logic           clk,
   input wire logic           reset_n,
   // Register bus
   input wire logic [4:0]     avs_address,
   input wire logic           avs_read,
   input wire logic           avs_write,
   input wire logic [31:0]    avs_writedata,
   input wire logic [3:0]     avs_byteenable,
   input wire logic [31:0]    avs_readdata,
   input wire logic           avs_waitrequest,
   // Pins and count
   input wire logic [NCH-1:0] wave_pin_o,
   input wire logic [NCH-1:0] wave_pin_oe_n,
   input wire logic [CW-1:0]  count_value
);
   tpwm_ctrl_t    ctrl;
   tpwm_port_t    port;
   logic [CW-1:0] capt;
   logic          done;
   logic          cnt_wr;
   assign done   = avs_write && !avs_waitrequest;
   assign cnt_wr = avs_write && avs_address == OFS_COUNT;
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl <= CTRL_RESET;
         port <= PORT_RESET;
         capt <= '0;
      end
      else if (done)
      begin
         if (avs_address == OFS_CTRL) ctrl <= tpwm_ctrl_t'(avs_writedata[10:0]);
         if (avs_address == OFS_PORT) port <= tpwm_port_t'(avs_writedata[3:0]);
         if (avs_address == OFS_CAPT) capt <= avs_writedata[CW-1:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered after one wait cycle");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_stop_hold: assert property (ctrl.clk_sel == CS_STOP && !cnt_wr |=> $stable(count_value))
      else $error("count moved while the timer clock was stopped");
   a_count_step: assert property (ctrl.clk_sel == CS_DIV1 && ctrl.waveform_mode_sel == WGM_FAST8
      && $stable(ctrl) && count_value < TOP_8 && !cnt_wr |=> count_value == $past(count_value) + 16'h1)
      else $error("count did not advance by one");
   a_fixed_top: assert property (ctrl.clk_sel == CS_DIV1 && ctrl.waveform_mode_sel == WGM_FAST8
      && $stable(ctrl) && count_value == TOP_8 && !cnt_wr |=> count_value == COUNT_BOTTOM)
      else $error("count not cleared after fixed TOP");
   a_capt_clear: assert property (ctrl.clk_sel == CS_DIV1 && ctrl.waveform_mode_sel == WGM_CTC_CAPT
      && $stable(ctrl) && count_value == capt && !cnt_wr |=> count_value == COUNT_BOTTOM)
      else $error("count not cleared on capture match");
   a_pin_dir: assert property ($stable(port) |-> wave_pin_oe_n[0] == !port.wave_pin_dir[0])
      else $error("pin enable does not follow direction bit");
   a_port_pass: assert property ($stable(port) && $stable(ctrl) && ctrl.out_mode_a == OM_OFF
      |-> wave_pin_o[0] == port.port_val[0])
      else $error("pin does not carry port value with output mode off");
   a_div8_gap: assert property (ctrl.clk_sel == CS_DIV8 && $stable(ctrl) && ctrl == $past(ctrl, 2)
      && $changed(count_value) && !$past(cnt_wr) |=> $stable(count_value) [*7])
      else $error("count changed sooner than eight cycles apart");
endmodule
bind tpwm_core tpwm_checker #(.NCH(NCH)) u_chk (
   .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wave_pin_o(wave_pin_o),
   .wave_pin_oe_n(wave_pin_oe_n), .count_value(count_value));

// file: tb/tb.sv
// Purpose: Self-checking bench of the timer waveform block
// Assumes: Whole-word register accesses, all byte lanes enabled
// Notes:   Duty is counted over two periods of a TOP of 9
`timescale 1ns/100ps
module tb;
   import tpwm_pkg::*;
   logic          clk;
   logic          reset_n;
   logic [4:0]    avs_address;
   logic          avs_read;
   logic          avs_write;
   logic [31:0]   avs_writedata;
   logic [3:0]    avs_byteenable;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic [1:0]    wave_pin_o;
   logic [1:0]    wave_pin_oe_n;
   logic [1:0]    pin_level;
   logic [CW-1:0] count_value;
   logic [31:0]   rdata;
   int            errors;
   int            cmp_count;
   int            g;
   logic [3:0]    tm[4] = '{WGM_CTC_A, WGM_CTC_CAPT, WGM_FAST_CAPT, WGM_FAST_A};
   logic [4:0]    ta[4] = '{OFS_CMP_A, OFS_CAPT, OFS_CAPT, OFS_CMP_A};
   logic [31:0]   tf[4] = '{32'h3, 32'h9, 32'h9, 32'h3};
   logic [1:0]    dom[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2};
   logic [31:0]   dcm[6] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h0, 32'h9};
   int            dex[6] = '{20, 10, 6, 14, 2, 20};
   int            dvs[5] = '{1, 8, 64, 256, 1024};
   logic [CW-1:0] tops[3] = '{TOP_8, TOP_9, TOP_10};
   tpwm_core #(.NCH(2)) dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .wave_pin_o(wave_pin_o),
      .wave_pin_oe_n(wave_pin_oe_n), .count_value(count_value));
   tpwm_load u_load (.wave_pin_o(wave_pin_o), .wave_pin_oe_n(wave_pin_oe_n),
      .pin_level(pin_level));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until waitrequest is sampled low at an edge
   task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge clk);
         t++;
      end
      while (avs_waitrequest !== 1'b0 && t < 20);
      check({31'h0, t >= 20}, 32'h0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      access(1'b0, a, 32'h0);
      check(rdata & m, e);
   endtask
   task automatic wait_cnt(input logic [CW-1:0] v);
      int t;
      t = 0;
      while (count_value !== v && t < 3000)
      begin
         @(posedge clk);
         t++;
      end
      check({16'h0, count_value}, {16'h0, v});
   endtask
   task automatic gap(output int n);
      logic [CW-1:0] v;
      int t;
      // Skip two changes: the divider phase is free running, so the first gap is partial
      repeat (2)
      begin
         t = 0;
         v = count_value;
         while (count_value === v && t < 3000)
         begin
            @(posedge clk);
            t++;
         end
      end
      v = count_value;
      n = 0;
      while (count_value === v && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   function automatic logic [31:0] cfg(input logic [3:0] md, input logic [2:0] cs,
                                       input logic [1:0] om);
      cfg = {21'h0, 2'h0, om, cs, md};
   endfunction
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #(8 * 20000);
      errors++;
      results();
   end
   initial
   begin
      errors = 0;
      cmp_count = 0;
      reset_n = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      check({30'h0, wave_pin_oe_n}, 32'h3);
      rdc(OFS_CTRL, 32'hffffffff, 32'h0);
      rdc(OFS_FLAGS, 32'hffffffff, 32'h0);
      rdc(5'h1c, 32'hffffffff, 32'h0);
      $display("test reset done");
      for (int k = 1; k <= 5; k++)
      begin
         access(1'b1, OFS_CTRL, cfg(WGM_FAST8, 3'(k), OM_OFF));
         gap(g);
         check(g, dvs[k - 1]);
      end
      access(1'b1, OFS_CTRL, cfg(WGM_FAST8, CS_DIV1, OM_OFF));
      wait_cnt(TOP_8);
      wait_cnt(COUNT_BOTTOM);
      $display("test prescaler done");
      for (int i = 0; i < 3; i++)
      begin
         access(1'b1, OFS_CTRL, cfg(4'(5 + i), CS_STOP, OM_OFF));
         access(1'b1, OFS_CMP_A, 32'hffff);
         access(1'b1, OFS_CMP_B, 32'hffff);
         rdc(OFS_CMP_A, 32'hffffffff, {16'h0, tops[i]});
         rdc(OFS_CMP_B, 32'hffffffff, {16'h0, tops[i]});
      end
      $display("test masking done");
      foreach (tm[i])
      begin
         access(1'b1, OFS_CTRL, cfg(tm[i], CS_STOP, OM_OFF));
         access(1'b1, ta[i], 32'h5);
         access(1'b1, OFS_COUNT, 32'hfff0);
         access(1'b1, OFS_FLAGS, 32'hf);
         access(1'b1, OFS_CTRL, cfg(tm[i], CS_DIV1, OM_OFF));
         wait_cnt(COUNT_MAX);
         wait_cnt(16'h0005);
         access(1'b1, OFS_CTRL, cfg(tm[i], CS_STOP, OM_OFF));
         rdc(OFS_FLAGS, tf[i], tf[i]);
      end
      $display("test top and flags done");
      access(1'b1, OFS_COUNT, 32'h0);
      // Outside PWM the compare write reaches the active value as well
      access(1'b1, OFS_CTRL, cfg(WGM_CTC_A, CS_STOP, OM_OFF));
      access(1'b1, OFS_CMP_A, 32'h7);
      access(1'b1, OFS_CTRL, cfg(WGM_FAST_A, CS_DIV1, OM_OFF));
      access(1'b1, OFS_CMP_A, 32'h3);
      wait_cnt(16'h0007);
      wait_cnt(16'h0003);
      @(posedge clk);
      check({16'h0, count_value}, 32'h0);
      $display("test buffered top done");
      access(1'b1, OFS_CAPT, 32'h9);
      access(1'b1, OFS_PORT, 32'h5);
      foreach (dom[i])
      begin
         access(1'b1, OFS_CTRL, cfg(WGM_FAST_CAPT, CS_DIV1, dom[i]));
         access(1'b1, OFS_CMP_A, dcm[i]);
         repeat (24) @(posedge clk);
         g = 0;
         repeat (20)
         begin
            @(posedge clk);
            g += int'(pin_level[0]);
         end
         check(g, dex[i]);
      end
      check({30'h0, wave_pin_oe_n}, 32'h2);
      check({30'h0, wave_pin_o}, 32'h1);
      $display("test duty done");
      results();
   end
endmodule
